// ---- rtl/pss_pkg.sv ----
// Constants and types for the pipelined synchronous SRAM port
package pss_pkg;
    localparam int ADDR_W     = 20;
    localparam int LANES      = 2;
    localparam int DATA_W     = 16;
    localparam int PAR_W      = 2;
    localparam int LANE_W     = 9;
    localparam int WORD_W     = DATA_W + PAR_W;
    localparam int DEPTH      = 1 << ADDR_W;
    localparam int BURST_LSB  = 0;
    localparam int BURST_W    = 2;
    localparam logic       HAS_CE3     = 1'b1;
    localparam logic [1:0] BURST_RESET = 2'h0;

    typedef enum logic [2:0] {
        PSS_IDLE  = 3'b001,
        PSS_READ  = 3'b010,
        PSS_WRITE = 3'b100
    } pss_state_t;
endpackage : pss_pkg

// ---- rtl/pss_mem_if.sv ----
// Interface between port logic and storage array
`timescale 1ns/100ps
interface pss_mem_if;
    import pss_pkg::*;
    logic                 rd_en;
    logic                 wr_en;
    logic [ADDR_W-1:0]    addr;
    logic [WORD_W-1:0]    wdata;
    logic [LANES-1:0]     lane_we;
    logic [WORD_W-1:0]    rdata;
    modport ctrl (output rd_en, output wr_en, output addr, output wdata, output lane_we, input rdata);
    modport mem  (input rd_en, input wr_en, input addr, input wdata, input lane_we, output rdata);
endinterface : pss_mem_if

// ---- rtl/pss_mem.sv ----
// Storage array with per-lane writes and registered read data
`timescale 1ns/100ps
module pss_mem (
    input  wire logic clk_sys,
    input  wire logic clk_en,
    pss_mem_if.mem    m
);
    import pss_pkg::*;

    // Lane k holds data byte k and parity bit k
    function automatic logic [LANE_W-1:0] lane_of(input logic [WORD_W-1:0] w, input int k);
        lane_of = {w[DATA_W+k], w[k*8 +: 8]};
    endfunction : lane_of

    // Each lane owns its array and read register, so every variable has one writer
    for (genvar k = 0; k < LANES; k++) begin : g_lane
        logic [LANE_W-1:0] store [DEPTH];
        logic [LANE_W-1:0] rd_q;
        always_ff @(posedge clk_sys) begin
            if (clk_en && m.wr_en && m.lane_we[k]) begin
                store[m.addr] <= lane_of(m.wdata, k);
            end
            if (clk_en && m.rd_en) begin
                rd_q <= store[m.addr];
            end
        end
        assign m.rdata[DATA_W+k] = rd_q[LANE_W-1];
        assign m.rdata[k*8 +: 8] = rd_q[7:0];
    end
endmodule : pss_mem

// ---- rtl/pss_port.sv ----
// Synchronous bus port of a pipelined burst SRAM
`timescale 1ns/100ps
module pss_port (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    input  wire logic [pss_pkg::ADDR_W-1:0]  addr,
    input  wire logic                        first_chip_enable_n,
    input  wire logic                        second_chip_enable,
    input  wire logic                        third_chip_enable_n,
    input  wire logic                        processor_addr_strobe_n,
    input  wire logic                        controller_addr_strobe_n,
    input  wire logic                        burst_advance_n,
    input  wire logic                        global_write_n,
    input  wire logic                        byte_write_enable_n,
    input  wire logic [pss_pkg::LANES-1:0]   byte_write_n,
    input  wire logic                        drive_enable_n,
    input  wire logic                        sleep_request,
    input  wire logic                        burst_order,
    input  wire logic [pss_pkg::DATA_W-1:0]  data_in,
    output logic      [pss_pkg::DATA_W-1:0]  data_out,
    output logic                             data_oe_n,
    input  wire logic [pss_pkg::PAR_W-1:0]   parity_in,
    output logic      [pss_pkg::PAR_W-1:0]   parity_out,
    output logic                             parity_oe_n,
    output logic                             sleeping
);
    import pss_pkg::*;

    typedef struct packed {
        pss_state_t        state;
        logic [ADDR_W-1:0] base;
        logic [1:0]        burst;
        logic [WORD_W-1:0] wdata;
        logic [LANES-1:0]  we_lanes;
        logic              read_out;
        logic              masked;
        logic              sleep_s1;
        logic              sleep_s2;
        logic              mode;
    } pss_regs_t;

    pss_regs_t r;
    pss_regs_t next_r;
    pss_mem_if mif ();

    // Burst sequence: linear adds, interleaved xors
    function automatic logic [1:0] burst_addr(input logic [1:0] start, input logic [1:0] cnt, input logic lin);
        burst_addr = lin ? 2'(start + cnt) : (start ^ cnt);
    endfunction : burst_addr

    logic sel;
    logic start_p;
    logic start_c;
    logic start;
    logic wr_now;
    logic [LANES-1:0] lanes;
    logic [ADDR_W-1:0] cur_addr;

    always_comb begin
        sel     = !first_chip_enable_n && second_chip_enable
                  && (HAS_CE3 ? !third_chip_enable_n : 1'b1);
        start_p = !processor_addr_strobe_n && !first_chip_enable_n;
        start_c = !controller_addr_strobe_n && !start_p;
        start   = start_p || start_c;
        // Processor strobe starts a read; writes follow in a later cycle
        wr_now  = !start_p && (!global_write_n || (!byte_write_enable_n && byte_write_n != {LANES{1'b1}}));
        lanes   = !global_write_n ? {LANES{1'b1}} : ~byte_write_n;
        cur_addr = {r.base[ADDR_W-1:BURST_W],
                    burst_addr(r.base[BURST_W-1:BURST_LSB], r.burst, !r.mode)};
    end

    always_comb begin
        next_r          = r;
        next_r.sleep_s1 = sleep_request;
        next_r.sleep_s2 = r.sleep_s1;
        next_r.wdata    = {parity_in, data_in};
        // Lane selects are registered with the data so the late write uses the write-cycle controls
        next_r.we_lanes = wr_now ? lanes : {LANES{1'b0}};
        next_r.read_out = 1'b0;
        next_r.masked   = 1'b0;
        if (r.sleep_s2) begin
            next_r.state = PSS_IDLE;
        end else if (start) begin
            if (sel) begin
                next_r.base     = addr;
                next_r.burst    = BURST_RESET;
                next_r.state    = (start_c && wr_now) ? PSS_WRITE : PSS_READ;
                next_r.read_out = !(start_c && wr_now);
                next_r.masked   = (r.state == PSS_IDLE) && !(start_c && wr_now);
            end else begin
                next_r.state = PSS_IDLE;
            end
        end else begin
            case (r.state)
                PSS_READ: begin
                    next_r.state    = wr_now ? PSS_WRITE : PSS_READ;
                    next_r.read_out = !wr_now;
                    if (!burst_advance_n) begin
                        next_r.burst = 2'(r.burst + 2'h1);
                    end
                end
                PSS_WRITE: begin
                    next_r.read_out = 1'b0;
                    if (!burst_advance_n) begin
                        next_r.burst = 2'(r.burst + 2'h1);
                    end
                end
                default: begin
                    next_r.state = PSS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r       <= '0;
            r.state <= PSS_IDLE;
            r.mode  <= 1'b1;
        end else if (clk_en) begin
            r <= next_r;
            if (r.state == PSS_IDLE && !r.read_out) begin
                r.mode <= burst_order;
            end
        end
    end

    // Write uses address and data registered at the previous edge
    assign mif.wr_en   = (r.state == PSS_WRITE) && !r.sleep_s2;
    assign mif.lane_we = r.we_lanes;
    assign mif.wdata   = r.wdata;
    assign mif.rd_en   = next_r.read_out;
    assign mif.addr    = mif.wr_en ? cur_addr
                         : (start && sel) ? addr
                         : {r.base[ADDR_W-1:BURST_W],
                            burst_addr(r.base[BURST_W-1:BURST_LSB], next_r.burst, !r.mode)};

    pss_mem u_mem (
        .clk_sys (clk_sys),
        .clk_en  (clk_en),
        .m       (mif.ctrl)
    );

    logic drive;
    assign drive       = !drive_enable_n && r.read_out && !r.masked;
    assign data_oe_n   = !drive;
    assign parity_oe_n = !drive;
    assign data_out    = mif.rdata[DATA_W-1:0];
    assign parity_out  = mif.rdata[WORD_W-1:DATA_W];
    assign sleeping    = r.sleep_s2;
endmodule : pss_port

// ---- verification/pss_host_model.sv ----
// Far-side controller model: sleep request and burst order strap
`timescale 1ns/100ps
module pss_host_model (
    input  wire logic clk_sys,
    input  wire logic want_sleep,
    input  wire logic want_linear,
    output logic      sleep_request = 1'h0,
    output logic      burst_order
);
    assign burst_order = !want_linear;
    always @(posedge clk_sys) sleep_request <= want_sleep;
endmodule : pss_host_model

// ---- verification/pss_port_checker.sv ----
// Pin-level assertions for the SRAM port
`timescale 1ns/100ps
module pss_port_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic first_chip_enable_n,
    input wire logic second_chip_enable,
    input wire logic third_chip_enable_n,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic drive_enable_n,
    input wire logic sleep_request,
    input wire logic data_oe_n,
    input wire logic parity_oe_n,
    input wire logic sleeping
);
    logic rd_go;
    logic desel;
    assign rd_go = clk_en && !first_chip_enable_n && second_chip_enable && !third_chip_enable_n && !sleeping &&
        !controller_addr_strobe_n && processor_addr_strobe_n && global_write_n && byte_write_enable_n;
    assign desel = clk_en && first_chip_enable_n && !controller_addr_strobe_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_oe_off; drive_enable_n |-> data_oe_n && parity_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pins driven with enable high");
    property p_oe_dir; !data_oe_n |-> !drive_enable_n; endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("drive without enable");
    property p_oe_pair; data_oe_n == parity_oe_n; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("data and parity enables differ");
    property p_mask; desel ##1 rd_go |-> ##1 data_oe_n; endproperty
    a_mask: assert property (p_mask) else $error("first read after deselect driven");
    property p_unmask; rd_go ##1 !burst_advance_n [*2] |-> ##1 (drive_enable_n || !data_oe_n); endproperty
    a_unmask: assert property (p_unmask) else $error("burst word not driven");
    property p_sleep_on; (sleep_request && clk_en) [*3] |-> ##[0:2] sleeping; endproperty
    a_sleep_on: assert property (p_sleep_on) else $error("sleep not entered");
    property p_sleep_off; (!sleep_request && clk_en) [*4] |-> !sleeping; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep not left");
    property p_sleep_sync; $rose(sleeping) |-> $past(sleep_request, 2); endproperty
    a_sleep_sync: assert property (p_sleep_sync) else $error("sleep without request");
    c_read: cover property (desel ##1 rd_go);
    c_burst: cover property (rd_go ##1 !burst_advance_n [*3]);
    c_sleep: cover property ($rose(sleeping));
endmodule : pss_port_checker
bind pss_port pss_port_checker u_chk (.*);

// ---- verification/pss_port_tb.sv ----
// Self-checking bench for the SRAM bus port
`timescale 1ns/100ps
module pss_port_tb;
    import pss_pkg::*;
    logic clk_sys, rst_n, clk_en, want_sleep, want_linear, sleep_request, burst_order, data_oe_n, parity_oe_n, sleeping;
    logic first_chip_enable_n, second_chip_enable, third_chip_enable_n, drive_enable_n;
    logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  byte_write_n;
    logic [DATA_W-1:0] data_in, data_out;
    logic [PAR_W-1:0]  parity_in, parity_out;
    int                fails = 0;
    int                n_tests = 0;
    pss_port dut (.*);
    pss_host_model partner (.*);
    function automatic logic [WORD_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return {a[1:0], 16'hA5C0 ^ a[15:0]};
    endfunction : pat
    task automatic cyc();
        @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input logic [WORD_W-1:0] exp_v, input logic [WORD_W-1:0] got);
        n_tests++;
        if (got !== exp_v) begin
            fails++;
            $display("ERROR at %0t: expected %h got %h", $time, exp_v, got);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        addr = a;
        {parity_in, data_in} = d;
        {controller_addr_strobe_n, global_write_n} = 2'h0;
        cyc();
        {controller_addr_strobe_n, global_write_n} = 2'h3;
        cyc();
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a);
        {first_chip_enable_n, controller_addr_strobe_n} = 2'h2;
        cyc();
        first_chip_enable_n = 1'h0;
        addr = a;
        cyc();
        controller_addr_strobe_n = 1'h1;
        cyc();
        chk(pat(a), {parity_out, data_out});
    endtask : rd
    task automatic t_write_read();
        for (int i = 0; i < 4; i++) wr(20'h00120 + i, pat(20'h00120 + i));
        for (int i = 0; i < 4; i++) rd(20'h00120 + i);
        $display("write and read done");
    endtask : t_write_read
    task automatic t_burst(input logic lin);
        logic [1:0] low;
        want_linear = lin;
        {first_chip_enable_n, controller_addr_strobe_n} = 2'h2;
        cyc();
        first_chip_enable_n = 1'h0;
        addr = 20'h00121;
        cyc();
        {controller_addr_strobe_n, burst_advance_n} = 2'h2;
        chk(18'h3, {16'h0, data_oe_n, parity_oe_n});
        chk(pat(addr), {parity_out, data_out});
        for (int k = 1; k < 4; k++) begin
            cyc();
            low = lin ? 2'(addr[1:0] + 2'(k)) : (addr[1:0] ^ 2'(k));
            chk(pat({addr[19:2], low}), {parity_out, data_out});
        end
        chk(18'h0, {16'h0, data_oe_n, parity_oe_n});
        burst_advance_n = 1'h1;
        drive_enable_n = 1'h1;
        #1;
        chk(18'h3, {16'h0, data_oe_n, parity_oe_n});
        drive_enable_n = 1'h0;
        $display("burst done");
    endtask : t_burst
    task automatic t_refuse();
        processor_addr_strobe_n = 1'h0;
        wr(20'h00122, 18'h3FFFF);
        chk(pat(20'h00122), {parity_out, data_out});
        processor_addr_strobe_n = 1'h1;
        third_chip_enable_n = 1'h1;
        wr(20'h00123, 18'h3FFFF);
        third_chip_enable_n = 1'h0;
        rd(20'h00122);
        rd(20'h00123);
        $display("refusals done");
    endtask : t_refuse
    task automatic t_sleep();
        want_sleep = 1'h1;
        repeat (6) cyc();
        chk(18'h1, {17'h0, sleeping});
        wr(20'h00120, 18'h0);
        want_sleep = 1'h0;
        repeat (6) cyc();
        chk(18'h0, {17'h0, sleeping});
        rd(20'h00120);
        $display("sleep done");
    endtask : t_sleep
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    initial begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #20000;
        fails++;
        give_verdict();
    end
    initial begin
        {rst_n, want_sleep, want_linear, first_chip_enable_n, third_chip_enable_n, drive_enable_n} = 6'h0;
        {clk_en, second_chip_enable, processor_addr_strobe_n, controller_addr_strobe_n} = 4'hF;
        {burst_advance_n, global_write_n, byte_write_enable_n, byte_write_n} = 5'h1F;
        {addr, data_in, parity_in} = '0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'h1;
        chk(18'h6, {15'h0, data_oe_n, parity_oe_n, sleeping});
        t_write_read();
        t_burst(1'h0);
        t_burst(1'h1);
        t_refuse();
        t_sleep();
        give_verdict();
    end
endmodule : pss_port_tb
